// ---- fbi_pkg.sv ----
// constants and carrier types for the flash array bus front end
package fbi_pkg;

	// ----------------------------------------
	// array geometry
	// ----------------------------------------
	localparam int ADDR_W          = 17;
	localparam int ARRAY_BYTES     = 131072;
	localparam int BLOCK_BYTES     = 16384;
	localparam int NUM_BLOCKS      = 8;
	localparam int BLOCK_LSB       = 14;
	localparam int READ_PAGE_WORDS = 8;
	localparam int READ_PAGE_LSB   = 5;
	localparam int PAGE_W          = ADDR_W - READ_PAGE_LSB;
	localparam int WORD_LSB        = 2;
	localparam int PROG_PAGE_BYTES = 64;
	localparam int PROG_PAGE_LSB   = 6;
	localparam int PROG_MAX_BYTES  = PROG_PAGE_BYTES * NUM_BLOCKS;

	// ----------------------------------------
	// control register map and fields
	// ----------------------------------------
	localparam logic [4:0] REG_MCR_OFS  = 5'h00;
	localparam logic [4:0] REG_MTR_OFS  = 5'h04;
	localparam logic [4:0] REG_HVC_OFS  = 5'h08;
	localparam int         MCR_STOP_BIT = 31;
	localparam int         MCR_OFF_BIT  = 25;
	localparam int         HVC_SEQ_BIT  = 0;
	localparam logic       STOP_RESET   = 1'h0;
	localparam logic       HV_RESET     = 1'h0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam logic [4:0] WAKE_CLOCKS = 5'h10;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic              wr;
		logic              reg_sel;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} fbi_req_t;

	typedef struct packed {
		logic        ack;
		logic        berr;
		logic [31:0] rdata;
	} fbi_rsp_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
	} fbi_prog_t;

endpackage

// ---- fbi_page_buf.sv ----
// one read page buffer: tag, valid flag and eight stored words
`timescale 1ns/10ps
module fbi_page_buf
	import fbi_pkg::*;
#(
	parameter int WORDS = READ_PAGE_WORDS,
	parameter int TAG_W = PAGE_W
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// fill side
	input  wire logic                     load_i,
	input  wire logic [TAG_W-1:0]         page_i,
	input  wire logic [WORDS*32-1:0]      data_i,
	// lookup side
	input  wire logic [TAG_W-1:0]         qpage_i,
	input  wire logic [$clog2(WORDS)-1:0] qword_i,
	output logic                          hit_o,
	output logic [31:0]                   word_o
);

	logic             valid_r;
	logic [TAG_W-1:0] tag_r;
	logic [31:0]      words_r [WORDS];

	assign hit_o  = valid_r && (tag_r == qpage_i);
	assign word_o = words_r[qword_i];

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			valid_r <= 1'b0;
			tag_r   <= '0;
		end else if (load_i) begin
			valid_r <= 1'b1;
			tag_r   <= page_i;
		end
	end

	// ----------------------------------------
	// word storage
	// ----------------------------------------
	for (genvar w = 0; w < WORDS; w++) begin : g_word
		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				words_r[w] <= '0;
			end else if (load_i) begin
				words_r[w] <= data_i[w*32 +: 32];
			end
		end
	end

endmodule

// ---- fbi_flash_front.sv ----
// bus front end of the flash array: modes, read page buffers, program writes
`timescale 1ns/10ps
module fbi_flash_front
	import fbi_pkg::*;
#(
	parameter logic OFF_RESET = 1'h0
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// system bus slave
	input  wire logic                  req_i,
	input  wire fbi_req_t              bus_i,
	output fbi_rsp_t                   rsp_o,
	// array read port
	output logic                       fetch_o,
	output logic [PAGE_W-1:0]          fetch_page_o,
	input  wire logic [READ_PAGE_WORDS*32-1:0] page_data_i,
	// array program port
	output fbi_prog_t                  prog_o,
	input  wire logic                  hv_done_i,
	// mode status
	output logic                       low_power_o,
	output logic                       array_off_o,
	output logic                       hv_active_o
);

	typedef enum logic {ST_IDLE, ST_FETCH} fbi_state_t;

	// ----------------------------------------
	// state
	// ----------------------------------------
	fbi_state_t        state_r, state_nxt;
	fbi_rsp_t          rsp_r, rsp_nxt;
	fbi_prog_t         prog_r, prog_nxt;
	logic              stop_r, stop_nxt;
	logic              off_r, off_nxt;
	logic              hv_r, hv_nxt;
	logic [4:0]        wake_cnt_r, wake_cnt_nxt;
	logic              prog_any_r, prog_any_nxt;
	logic [7:0]        prog_ofs_r, prog_ofs_nxt;
	logic [ADDR_W-1:0] pend_addr_r, pend_addr_nxt;

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	wire logic       take      = req_i && (state_r == ST_IDLE) && !rsp_r.ack && !rsp_r.berr;
	wire logic [4:0] reg_ofs   = bus_i.addr[4:0];
	wire logic       is_mcr    = (reg_ofs == REG_MCR_OFS);
	wire logic       is_mtr    = (reg_ofs == REG_MTR_OFS);
	wire logic       is_hvc    = (reg_ofs == REG_HVC_OFS);
	wire logic       reg_take  = take && bus_i.reg_sel;
	wire logic       reg_berr  = stop_r ? !is_mcr : !(is_mcr || is_mtr || is_hvc);
	// array accesses vanish while stopped or disabled; clearing the off bit acts at once
	wire logic       arr_take  = take && !bus_i.reg_sel && !off_r && !stop_r;
	wire logic       arr_rd    = arr_take && !bus_i.wr && (wake_cnt_r == 5'h00);
	wire logic       arr_wr    = arr_take && bus_i.wr;
	wire logic       mcr_wr    = reg_take && bus_i.wr && is_mcr && !hv_r;
	wire logic       hvc_wr    = reg_take && bus_i.wr && is_hvc && !stop_r;
	wire logic       hv_start  = hvc_wr && !hv_r && bus_i.wdata[HVC_SEQ_BIT];

	// block index picks the read buffer and the program page
	wire logic [2:0] blk_idx   = bus_i.addr[ADDR_W-1:BLOCK_LSB];
	wire logic       upper     = blk_idx[2];
	wire logic [7:0] req_ofs   = bus_i.addr[BLOCK_LSB-1:PROG_PAGE_LSB];
	// all pages of one operation share the block offset, so at most 512 bytes
	wire logic       prog_ok   = hv_r && (!prog_any_r || (req_ofs == prog_ofs_r));

	// ----------------------------------------
	// read page buffers
	// ----------------------------------------
	logic        hit_lo, hit_hi;
	logic [31:0] word_lo, word_hi;
	wire logic   pend_up  = pend_addr_r[ADDR_W-1];
	wire logic   fill_lo  = (state_r == ST_FETCH) && !pend_up;
	wire logic   fill_hi  = (state_r == ST_FETCH) && pend_up;
	wire logic   hit      = upper ? hit_hi : hit_lo;
	wire logic [31:0] hit_word = upper ? word_hi : word_lo;
	wire logic [2:0] pend_word = pend_addr_r[READ_PAGE_LSB-1:WORD_LSB];
	wire logic [31:0] fill_word = page_data_i[pend_word*32 +: 32];

	fbi_page_buf u_buf_lo (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.load_i  (fill_lo),
		.page_i  (pend_addr_r[ADDR_W-1:READ_PAGE_LSB]),
		.data_i  (page_data_i),
		.qpage_i (bus_i.addr[ADDR_W-1:READ_PAGE_LSB]),
		.qword_i (bus_i.addr[READ_PAGE_LSB-1:WORD_LSB]),
		.hit_o   (hit_lo),
		.word_o  (word_lo)
	);

	fbi_page_buf u_buf_hi (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.load_i  (fill_hi),
		.page_i  (pend_addr_r[ADDR_W-1:READ_PAGE_LSB]),
		.data_i  (page_data_i),
		.qpage_i (bus_i.addr[ADDR_W-1:READ_PAGE_LSB]),
		.qword_i (bus_i.addr[READ_PAGE_LSB-1:WORD_LSB]),
		.hit_o   (hit_hi),
		.word_o  (word_hi)
	);

	// ----------------------------------------
	// register read values
	// ----------------------------------------
	logic [31:0] mcr_val, hvc_val;
	always_comb begin
		mcr_val               = '0;
		mcr_val[MCR_STOP_BIT] = stop_r;
		mcr_val[MCR_OFF_BIT]  = off_r;
		hvc_val               = '0;
		hvc_val[HVC_SEQ_BIT]  = hv_r;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_nxt     = state_r;
		rsp_nxt       = '0;
		prog_nxt      = '0;
		stop_nxt      = mcr_wr ? bus_i.wdata[MCR_STOP_BIT] : stop_r;
		off_nxt       = mcr_wr ? bus_i.wdata[MCR_OFF_BIT] : off_r;
		hv_nxt        = hv_r;
		wake_cnt_nxt  = (wake_cnt_r != 5'h00) ? wake_cnt_r - 5'h01 : wake_cnt_r;
		prog_any_nxt  = prog_any_r;
		prog_ofs_nxt  = prog_ofs_r;
		pend_addr_nxt = pend_addr_r;
		if (stop_r && !stop_nxt) begin
			wake_cnt_nxt = WAKE_CLOCKS;
		end
		// a start write beats a completion in the same cycle
		if (hvc_wr) begin
			hv_nxt = bus_i.wdata[HVC_SEQ_BIT];
		end else if (hv_done_i) begin
			hv_nxt = 1'b0;
		end
		if (hv_start) begin
			prog_any_nxt = 1'b0;
		end
		if (reg_take) begin
			rsp_nxt.ack  = !reg_berr;
			rsp_nxt.berr = reg_berr;
			if (!reg_berr && !bus_i.wr) begin
				rsp_nxt.rdata = is_mcr ? mcr_val : (is_hvc ? hvc_val : 32'h0000_0000);
			end
		end
		if (arr_wr) begin
			if (prog_ok) begin
				rsp_nxt.ack   = 1'b1;
				prog_nxt.we   = 1'b1;
				prog_nxt.addr = bus_i.addr;
				prog_nxt.data = bus_i.wdata;
				prog_any_nxt  = 1'b1;
				prog_ofs_nxt  = req_ofs;
			end else begin
				rsp_nxt.berr = 1'b1;
			end
		end
		if (arr_rd) begin
			pend_addr_nxt = bus_i.addr;
			if (hit) begin
				rsp_nxt.ack   = 1'b1;
				rsp_nxt.rdata = hit_word;
			end else begin
				state_nxt = ST_FETCH;
			end
		end
		case (state_r)
			ST_IDLE: begin
			end
			ST_FETCH: begin
				rsp_nxt.ack   = 1'b1;
				rsp_nxt.rdata = fill_word;
				state_nxt     = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r     <= ST_IDLE;
			rsp_r       <= '0;
			prog_r      <= '0;
			stop_r      <= STOP_RESET;
			off_r       <= OFF_RESET;
			hv_r        <= HV_RESET;
			wake_cnt_r  <= 5'h00;
			prog_any_r  <= 1'b0;
			prog_ofs_r  <= 8'h00;
			pend_addr_r <= '0;
		end else begin
			state_r     <= state_nxt;
			rsp_r       <= rsp_nxt;
			prog_r      <= prog_nxt;
			stop_r      <= stop_nxt;
			off_r       <= off_nxt;
			hv_r        <= hv_nxt;
			wake_cnt_r  <= wake_cnt_nxt;
			prog_any_r  <= prog_any_nxt;
			prog_ofs_r  <= prog_ofs_nxt;
			pend_addr_r <= pend_addr_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rsp_o        = rsp_r;
	assign prog_o       = prog_r;
	assign fetch_o      = (state_r == ST_FETCH);
	assign fetch_page_o = pend_addr_r[ADDR_W-1:READ_PAGE_LSB];
	assign low_power_o  = stop_r;
	assign array_off_o  = off_r;
	assign hv_active_o  = hv_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_stop_no_fetch: assert property (low_power_o |-> !fetch_o)
		else $error("array fetched while in stop mode");
	chk_stop_ignores_array: assert property (
		take && !bus_i.reg_sel && stop_r |=> !rsp_r.ack && !rsp_r.berr)
		else $error("array access answered in stop mode");
	chk_stop_reg_berr: assert property (
		reg_take && stop_r && !is_mcr |=> rsp_r.berr && !rsp_r.ack)
		else $error("non-config register access in stop mode not refused");
	chk_mode_bits_locked: assert property (
		reg_take && bus_i.wr && is_mcr && hv_r |=> $stable(stop_r) && $stable(off_r))
		else $error("mode bit changed during high-voltage sequence");
	chk_wake_load: assert property ($fell(stop_r) |-> wake_cnt_r == WAKE_CLOCKS)
		else $error("wake count not loaded on stop exit");
	chk_wake_holds_reads: assert property (
		take && !bus_i.reg_sel && !bus_i.wr && !off_r && !stop_r && (wake_cnt_r != 5'h00)
		|=> !rsp_r.ack && !fetch_o)
		else $error("array read served during wake-up");
	chk_off_silent: assert property (
		take && !bus_i.reg_sel && off_r |=> !rsp_r.ack && !rsp_r.berr && !fetch_o)
		else $error("disabled array answered");
	chk_hit_one_clock: assert property (arr_rd && hit |=> rsp_r.ack && !rsp_r.berr)
		else $error("on-page read not answered in one clock");
	chk_miss_two_clocks: assert property (
		arr_rd && !hit |=> fetch_o && !rsp_r.ack ##1 rsp_r.ack && !fetch_o)
		else $error("off-page read not answered in two clocks");
	chk_array_write_berr: assert property (arr_wr && !hv_r |=> rsp_r.berr)
		else $error("array write outside sequence not refused");
	chk_seq_start: assert property (hv_start |=> hv_active_o)
		else $error("sequence bit not set by start write");
	chk_prog_same_ofs: assert property (
		arr_wr && hv_r && prog_any_r && (req_ofs != prog_ofs_r) |=> rsp_r.berr && !prog_r.we)
		else $error("program page at another block offset accepted");

	cov_on_page: cover property (arr_rd && hit ##1 rsp_r.ack);
	cov_off_page: cover property (arr_rd && !hit ##2 rsp_r.ack);
	cov_wake_read: cover property ($fell(stop_r) ##[1:20] arr_rd);
	cov_prog_write: cover property (prog_r.we);

endmodule

// ---- fbi_bus_master.sv ----
// bus master model for the flash front end: one access at a time
`timescale 1ns/10ps
module fbi_bus_master
	import fbi_pkg::*;
(
	// clock
	input  wire logic     clk_i,
	// request side
	output logic          req_o,
	output fbi_req_t      bus_o,
	// answer side
	input  wire fbi_rsp_t rsp_i
);
	initial begin
		req_o = 1'h0;
		bus_o = '0;
	end

	// ----------------------------------------
	// access task
	// ----------------------------------------
	// request held until ack or berr is sampled; maxc bounds a silent slave
	task automatic xfer(input logic wr, input logic rs, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input int maxc, output logic [1:0] res,
		output logic [31:0] rd, output int cyc);
		@(posedge clk_i);
		#1;
		req_o = 1'h1;
		bus_o = '{wr: wr, reg_sel: rs, addr: a, wdata: d};
		res = 2'h0;
		rd = 32'h0;
		cyc = 0;
		while (res == 2'h0 && cyc < maxc) begin
			@(posedge clk_i);
			cyc++;
			res = {rsp_i.ack, rsp_i.berr};
			rd = rsp_i.rdata;
		end
		#1;
		req_o = 1'h0;
		bus_o = ~bus_o;  // released lines carry no stale request
	endtask
endmodule

// ---- fbi_flash_front_tb_top.sv ----
// self-checking bench for the flash array bus front end
`timescale 1ns/10ps
module fbi_flash_front_tb_top
	import fbi_pkg::*;
;
	logic                          clk_i = 1'h0;
	logic                          reset_i = 1'h1;
	logic                          hv_done = 1'h0;
	logic                          req;
	fbi_req_t                      bus;
	fbi_rsp_t                      rsp;
	fbi_prog_t                     prog;
	logic                          fetch;
	logic                          low_power;
	logic                          array_off;
	logic                          hv_active;
	logic [PAGE_W-1:0]             fetch_page;
	logic [PAGE_W-1:0]             last_fp;
	logic [READ_PAGE_WORDS*32-1:0] pg;
	logic [READ_PAGE_WORDS*32-1:0] page_data;
	logic [ADDR_W-1:0]             last_pa;
	logic [31:0]                   last_pd;
	logic [1:0]                    res;
	logic [31:0]                   rd;
	int                            cyc;
	int                            n_mismatch = 0;
	int                            compares = 0;
	int                            n_cyc = 0;
	int                            n_fetch = 0;
	int                            n_prog = 0;

	initial forever #50 clk_i = ~clk_i;

	fbi_flash_front dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req), .bus_i(bus),
		.rsp_o(rsp), .fetch_o(fetch), .fetch_page_o(fetch_page), .page_data_i(page_data),
		.prog_o(prog), .hv_done_i(hv_done), .low_power_o(low_power),
		.array_off_o(array_off), .hv_active_o(hv_active));
	fbi_bus_master u_master (.clk_i(clk_i), .req_o(req), .bus_o(bus), .rsp_i(rsp));

	// ----------------------------------------
	// array model and monitors
	// ----------------------------------------
	always_comb begin
		for (int n = 0; n < READ_PAGE_WORDS; n++)
			pg[n*32 +: 32] = {8'ha5, 4'h0, fetch_page, 5'h00, 3'(n)};
		page_data = fetch ? pg : ~pg;  // no stale data outside the fetch cycle
	end

	always @(posedge clk_i) begin
		n_cyc++;
		if (fetch === 1'h1) begin
			n_fetch++;
			last_fp = fetch_page;
		end
		if (prog.we === 1'h1) begin
			n_prog++;
			last_pa = prog.addr;
			last_pd = prog.data;
		end
		if (n_cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] exp_word(input logic [ADDR_W-1:0] a);
		return {8'ha5, 4'h0, a[16:5], 5'h00, a[4:2]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t ns: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic chk_in(input int v, input int lo, input int hi, input string msg);
		compares++;
		if (v < lo || v > hi) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t ns: %s took %0d cycles", $time, msg, v);
		end
	endtask

	task automatic go(input logic wr, input logic rs, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input int maxc);
		u_master.xfer(wr, rs, a, d, maxc, res, rd, cyc);
	endtask

	task automatic rd_arr(input logic [ADDR_W-1:0] a, input logic miss);
		int f0;
		f0 = n_fetch;
		go(1'h0, 1'h0, a, 32'h0, 10);
		chk({30'h0, res}, 32'h2, "array read answer");
		chk(rd, exp_word(a), "array read data");
		chk_in(cyc, miss ? 3 : 2, miss ? 3 : 2, "array read");
		chk(32'(n_fetch - f0), {31'h0, miss}, "page fetch count");
		if (miss)
			chk(32'(last_fp), 32'(a[16:5]), "fetched page");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_pages();
		rd_arr(17'h00024, 1'h1);
		rd_arr(17'h00038, 1'h0);
		rd_arr(17'h1c004, 1'h1);
		rd_arr(17'h0003c, 1'h0);
		rd_arr(17'h1c01c, 1'h0);
		rd_arr(17'h04000, 1'h1);
		rd_arr(17'h1c000, 1'h0);
		rd_arr(17'h00020, 1'h1);
		rd_arr(17'h0fffc, 1'h1);
		rd_arr(17'h10000, 1'h1);
		rd_arr(17'h0ffe0, 1'h0);
	endtask

	task automatic t_stop();
		int cw;
		go(1'h1, 1'h1, 17'(REG_MCR_OFS), 32'h1 << MCR_STOP_BIT, 10);
		chk(32'(low_power), 32'h1, "stop level");
		go(1'h0, 1'h0, 17'h00024, 32'h0, 20);
		chk(32'(res), 32'h0, "read in stop");
		go(1'h1, 1'h0, 17'h00024, 32'h0, 20);
		chk(32'(res), 32'h0, "write in stop");
		go(1'h0, 1'h1, 17'(REG_MTR_OFS), 32'h0, 10);
		chk(32'(res), 32'h1, "test reg in stop");
		go(1'h0, 1'h1, 17'(REG_MCR_OFS), 32'h0, 10);
		chk({30'h0, res}, 32'h2, "config reg in stop");
		chk(32'(rd[MCR_STOP_BIT]), 32'h1, "config readback");
		go(1'h1, 1'h1, 17'(REG_MCR_OFS), 32'h0, 10);
		cw = cyc;
		chk(32'(low_power), 32'h0, "stop cleared");
		go(1'h0, 1'h0, 17'h00024, 32'h0, 40);
		chk({30'h0, res}, 32'h2, "read after wake");
		chk_in(cw + cyc, 17, 19, "wake read");
	endtask

	task automatic t_disable();
		go(1'h1, 1'h1, 17'(REG_MCR_OFS), 32'h1 << MCR_OFF_BIT, 10);
		chk(32'(array_off), 32'h1, "disable level");
		go(1'h0, 1'h0, 17'h00024, 32'h0, 20);
		chk(32'(res), 32'h0, "read when disabled");
		go(1'h0, 1'h1, 17'(REG_MTR_OFS), 32'h0, 10);
		chk({30'h0, res}, 32'h2, "reg when disabled");
		go(1'h1, 1'h1, 17'(REG_MCR_OFS), 32'h0, 10);
		go(1'h0, 1'h0, 17'h00024, 32'h0, 10);
		chk({30'h0, res}, 32'h2, "read re-enabled");
		chk_in(cyc, 2, 2, "re-enabled read");
	endtask

	task automatic t_program();
		int p0;
		go(1'h1, 1'h0, 17'h00100, 32'h0, 10);
		chk(32'(res), 32'h1, "write outside sequence");
		go(1'h1, 1'h1, 17'(REG_HVC_OFS), 32'h1, 10);
		chk(32'(hv_active), 32'h1, "sequence start");
		go(1'h1, 1'h1, 17'(REG_MCR_OFS), 32'h1 << MCR_STOP_BIT, 10);
		chk(32'(low_power), 32'h0, "stop locked");
		go(1'h1, 1'h1, 17'(REG_MCR_OFS), 32'h1 << MCR_OFF_BIT, 10);
		chk(32'(array_off), 32'h0, "disable locked");
		p0 = n_prog;
		for (int b = 0; b < NUM_BLOCKS; b++) begin
			go(1'h1, 1'h0, {b[2:0], 8'h05, 6'h08}, 32'h0ba0_0000 + b, 10);
			chk({30'h0, res}, 32'h2, "programming write");
		end
		go(1'h1, 1'h0, {3'h2, 8'h06, 6'h08}, 32'h0, 10);
		chk(32'(res), 32'h1, "other offset");
		repeat (2) @(posedge clk_i);
		chk(32'(n_prog - p0), 32'h8, "pages taken");
		chk(32'(last_pa), 32'(17'h1c148), "last program addr");
		chk(last_pd, 32'h0ba0_0007, "last program data");
		#1;
		hv_done = 1'h1;
		@(posedge clk_i);
		#1;
		hv_done = 1'h0;
		@(posedge clk_i);
		#1;
		chk(32'(hv_active), 32'h0, "sequence over");
		go(1'h1, 1'h0, 17'h00100, 32'h0, 10);
		chk(32'(res), 32'h1, "write after sequence");
	endtask

	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		#1;
		reset_i = 1'h0;
		chk({29'h0, low_power, array_off, hv_active}, 32'h0, "levels after reset");
		t_pages();
		t_stop();
		t_disable();
		t_program();
		give_verdict();
	end
endmodule
